// File: hw/pmr_params.svh
// constants of the power mode and reset control block
`ifndef PMR_PARAMS_SVH
`define PMR_PARAMS_SVH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define PMR_ADDR_PORT0     8'h80
`define PMR_ADDR_STACK     8'h81
`define PMR_ADDR_POWER     8'h87
`define PMR_ADDR_PORT1     8'h90
`define PMR_ADDR_SERIAL    8'h99
`define PMR_ADDR_PORT2     8'ha0
`define PMR_ADDR_PORT3     8'hb0

// ----------------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------------
`define PMR_BIT_IDLE       0
`define PMR_BIT_PDOWN      1
`define PMR_PWR_KEEP_MASK  8'h10
`define PMR_PWR_POR        8'h30
`define PMR_STACK_RST      8'h07
`define PMR_PORT_RST       8'hff

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define PMR_OSC_PERIOD_NS  25
`define PMR_OSC_PER_MC     12
`define PMR_S5P2_IDX       9
`define PMR_RST_HOLD_MC    2

`endif

// File: hw/pmr_pkg.sv
// types shared by the power mode and reset control block
package pmr_pkg;

   typedef enum logic [2:0] {
      PMR_RUN   = 3'b001,
      PMR_IDLE  = 3'b010,
      PMR_PDOWN = 3'b100
   } pmr_mode_t;

   typedef struct packed {
      logic       sync1;
      logic       sync2;
      logic [1:0] hold_cnt;
      logic       chip_rst;
   } pmr_filt_st_t;

   typedef struct packed {
      pmr_mode_t   mode;
      logic [3:0]  mc_cnt;
      logic [7:0]  power_control;
      logic [7:0]  stack;
      logic [31:0] ports;
      logic [7:0]  serial_buffer;
      logic [7:0]  rdata;
      logic        wake;
      logic [1:0]  irq_s1;
      logic [1:0]  irq_s2;
   } pmr_top_st_t;

endpackage

// File: hw/pmr_rst_filter.sv
// reset pin synchroniser and machine-cycle hold filter
`timescale 1ns/1ps
`include "pmr_params.svh"

module pmr_rst_filter
   import pmr_pkg::*;
#(
   parameter int HOLD_MC = `PMR_RST_HOLD_MC
) (
   // clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_arst_n,
   // sampling
   input  wire logic i_sample,
   input  wire logic i_rst_pin,
   // results
   output logic      o_pin_sync,
   output logic      o_chip_rst
);

   initial begin
      if (HOLD_MC < 1 || HOLD_MC > 3) begin
         $error("pmr_rst_filter: HOLD_MC must be 1 to 3");
      end
   end

   localparam logic [1:0] HOLD = 2'(HOLD_MC);

   pmr_filt_st_t s_q;
   pmr_filt_st_t s_d;

   always_comb begin
      s_d       = s_q;
      s_d.sync1 = i_rst_pin;
      s_d.sync2 = s_q.sync1;
      // with HOLD_MC of two or more, a single high sample is a glitch and never starts a reset
      if (i_sample) begin
         if (!s_q.sync2) begin
            s_d.hold_cnt = 2'h0;
            s_d.chip_rst = 1'b0;
         end else if (s_q.hold_cnt >= HOLD - 2'h1) begin
            s_d.hold_cnt = HOLD;
            s_d.chip_rst = 1'b1;
         end else begin
            s_d.hold_cnt = s_q.hold_cnt + 2'h1;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign o_pin_sync = s_q.sync2;
   assign o_chip_rst = s_q.chip_rst;

   property p_sample_only;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         !i_sample |=> $stable(s_q.hold_cnt) && $stable(s_q.chip_rst);
   endproperty
   a_sample_only: assert property (p_sample_only) else $error("reset sampled off S5P2");

   property p_no_glitch;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         $rose(s_q.chip_rst) |-> $past(s_q.hold_cnt) == HOLD - 2'h1 && $past(s_q.sync2);
   endproperty
   a_no_glitch: assert property (p_no_glitch) else $error("reset started by short pulse");

endmodule

// File: hw/pmr_top.sv
// power mode and reset control top level
`timescale 1ns/1ps
`include "pmr_params.svh"

// Function
// - writing one to idle_request_bit enters idle mode
// - idle gates the processor core clock off
// - idle keeps peripheral and interrupt logic clocks running
// - any taken interrupt or reset leaves idle and restores core clock
// - writing one to powerdown_request_bit enters power-down mode
// - power-down stops all internal clocks and the oscillator
// - power-down exits only on reset or enabled level ext_irq_zero/one
// - security bit 7 at zero selects half-gain oscillator amplifier
// - reset pin sampled once per machine cycle at state five phase two
// - short reset glitches are filtered and never start a reset
// - reset loads every port latch with all ones
// - reset loads stack pointer with seven
// - reset clears power_control except bit four, which stays
// - reset clears other registers; serial_buffer stays untouched
// - oscillator clock is divided by two before internal use
module pmr_top
   import pmr_pkg::*;
#(
   parameter int OSC_PER_MC = `PMR_OSC_PER_MC,
   parameter int S5P2_IDX   = `PMR_S5P2_IDX,
   parameter int HOLD_MC    = `PMR_RST_HOLD_MC
) (
   // clock and reset
   input  wire logic        i_core_clk,
   input  wire logic        i_arst_n,
   // register port
   input  wire logic [7:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [7:0]  o_rdata,
   // pins
   input  wire logic        i_rst_pin,
   input  wire logic        i_ext_irq_zero_n,
   input  wire logic        i_ext_irq_one_n,
   // interrupt logic
   input  wire logic        i_irq_taken,
   input  wire logic [1:0]  i_ext_irq_en,
   input  wire logic [1:0]  i_ext_irq_level,
   // nonvolatile security byte
   input  wire logic        i_sec_bit7,
   // clock control
   output logic             o_core_clk_en,
   output logic             o_periph_clk_en,
   output logic             o_osc_en,
   output logic             o_osc_low_gain,
   // reset and register state
   output logic             o_chip_rst,
   output logic             o_wake_irq,
   output logic      [7:0]  o_power_control,
   output logic      [7:0]  o_stack,
   output logic      [31:0] o_ports,
   output logic      [7:0]  o_serial_buffer,
   output logic      [2:0]  o_mode
);

   initial begin
      if (OSC_PER_MC < 2 || OSC_PER_MC > 16 || OSC_PER_MC % 2 != 0) begin
         $error("pmr_top: OSC_PER_MC must be even, 2 to 16");
      end
      if (S5P2_IDX < 0 || S5P2_IDX >= OSC_PER_MC) begin
         $error("pmr_top: S5P2_IDX out of range");
      end
   end

   localparam logic [3:0] MC_LAST = 4'(OSC_PER_MC - 1);
   localparam logic [3:0] S5P2    = 4'(S5P2_IDX);

   // ---------------------------------------------------------------------------
   // state
   // ---------------------------------------------------------------------------
   pmr_top_st_t s_q;
   pmr_top_st_t s_d;

   logic       sample;
   logic       pin_sync;
   logic       chip_rst;
   logic       phase;
   logic       wr_power;
   logic       pd_wake;

   assign sample = s_q.mode != PMR_PDOWN && s_q.mc_cnt == S5P2;
   // odd oscillator clocks only: internal clocks run at half rate
   assign phase  = s_q.mc_cnt[0];
   assign wr_power = i_wr && i_addr == `PMR_ADDR_POWER;
   // level-triggered, enabled external interrupts only
   assign pd_wake = |(i_ext_irq_en & i_ext_irq_level & ~s_q.irq_s2);

   // ---------------------------------------------------------------------------
   // reset pin filter
   // ---------------------------------------------------------------------------
   pmr_rst_filter #(
      .HOLD_MC (HOLD_MC)
   ) u_filter (
      .i_core_clk (i_core_clk),
      .i_arst_n   (i_arst_n),
      .i_sample   (sample),
      .i_rst_pin  (i_rst_pin),
      .o_pin_sync (pin_sync),
      .o_chip_rst (chip_rst)
   );

   // ---------------------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------------------
   always_comb begin
      s_d        = s_q;
      s_d.wake   = 1'b0;
      s_d.rdata  = 8'h00;
      s_d.irq_s1 = {i_ext_irq_one_n, i_ext_irq_zero_n};
      s_d.irq_s2 = s_q.irq_s1;

      // machine-cycle counter freezes with the oscillator
      if (s_q.mode != PMR_PDOWN) begin
         s_d.mc_cnt = (s_q.mc_cnt == MC_LAST) ? 4'h0 : s_q.mc_cnt + 4'h1;
      end

      // register writes
      if (i_wr) begin
         case (i_addr)
            `PMR_ADDR_POWER:  s_d.power_control = i_wdata;
            `PMR_ADDR_STACK:  s_d.stack = i_wdata;
            `PMR_ADDR_PORT0:  s_d.ports[7:0] = i_wdata;
            `PMR_ADDR_PORT1:  s_d.ports[15:8] = i_wdata;
            `PMR_ADDR_PORT2:  s_d.ports[23:16] = i_wdata;
            `PMR_ADDR_PORT3:  s_d.ports[31:24] = i_wdata;
            `PMR_ADDR_SERIAL: s_d.serial_buffer = i_wdata;
            default: begin
            end
         endcase
      end

      // register reads, answered one cycle later, unmapped reads zero
      if (i_rd) begin
         case (i_addr)
            `PMR_ADDR_POWER:  s_d.rdata = s_q.power_control;
            `PMR_ADDR_STACK:  s_d.rdata = s_q.stack;
            `PMR_ADDR_PORT0:  s_d.rdata = s_q.ports[7:0];
            `PMR_ADDR_PORT1:  s_d.rdata = s_q.ports[15:8];
            `PMR_ADDR_PORT2:  s_d.rdata = s_q.ports[23:16];
            `PMR_ADDR_PORT3:  s_d.rdata = s_q.ports[31:24];
            `PMR_ADDR_SERIAL: s_d.rdata = s_q.serial_buffer;
            default:          s_d.rdata = 8'h00;
         endcase
      end

      // power modes
      case (s_q.mode)
         PMR_RUN: begin
            // power-down wins when both request bits are written together
            if (wr_power && i_wdata[`PMR_BIT_PDOWN]) begin
               s_d.mode = PMR_PDOWN;
            end else if (wr_power && i_wdata[`PMR_BIT_IDLE]) begin
               s_d.mode = PMR_IDLE;
            end else if (s_q.power_control[`PMR_BIT_PDOWN] && !pin_sync) begin
               // pin fell before the filter took it: a glitch, so sleep again
               s_d.mode = PMR_PDOWN;
            end
         end
         PMR_IDLE: begin
            if (i_irq_taken) begin
               s_d.mode = PMR_RUN;
               s_d.power_control[`PMR_BIT_IDLE] = 1'b0;
               s_d.wake = 1'b1;
            end
         end
         PMR_PDOWN: begin
            if (pd_wake) begin
               s_d.mode = PMR_RUN;
               s_d.power_control[`PMR_BIT_PDOWN] = 1'b0;
               s_d.wake = 1'b1;
            end else if (pin_sync) begin
               // restart the oscillator so the filter can sample the pin
               s_d.mode = PMR_RUN;
            end
         end
         default: begin
            s_d.mode = PMR_RUN;
         end
      endcase

      // filtered reset overrides mode, wake, ports, stack and power_control except bit four; not the serial buffer
      if (chip_rst) begin
         s_d.mode          = PMR_RUN;
         s_d.wake          = 1'b0;
         s_d.ports         = {4{`PMR_PORT_RST}};
         s_d.stack         = `PMR_STACK_RST;
         s_d.power_control = s_q.power_control & `PMR_PWR_KEEP_MASK;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         s_q.mode          <= PMR_RUN;
         s_q.mc_cnt        <= 4'h0;
         s_q.power_control <= `PMR_PWR_POR;
         s_q.stack         <= `PMR_STACK_RST;
         s_q.ports         <= {4{`PMR_PORT_RST}};
         s_q.serial_buffer <= 8'h00;
         s_q.rdata         <= 8'h00;
         s_q.wake          <= 1'b0;
         s_q.irq_s1        <= 2'h3;
         s_q.irq_s2        <= 2'h3;
      end else begin
         s_q <= s_d;
      end
   end

   // ---------------------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------------------
   assign o_core_clk_en   = phase && s_q.mode == PMR_RUN;
   assign o_periph_clk_en = phase && s_q.mode != PMR_PDOWN;
   assign o_osc_en        = s_q.mode != PMR_PDOWN;
   // fuse is static, no synchroniser needed
   assign o_osc_low_gain  = !i_sec_bit7;
   assign o_chip_rst      = chip_rst;
   assign o_wake_irq      = s_q.wake;
   assign o_rdata         = s_q.rdata;
   assign o_power_control = s_q.power_control;
   assign o_stack         = s_q.stack;
   assign o_ports         = s_q.ports;
   assign o_serial_buffer = s_q.serial_buffer;
   assign o_mode          = s_q.mode;

   // ---------------------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------------------
   property p_idle_entry;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         s_q.mode == PMR_RUN && wr_power && i_wdata[0] && !i_wdata[1] && !chip_rst
            |=> s_q.mode == PMR_IDLE;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

   property p_core_gated;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         s_q.mode != PMR_RUN |-> !o_core_clk_en;
   endproperty
   a_core_gated: assert property (p_core_gated) else $error("core clock runs in idle");

   property p_periph_runs;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         s_q.mode == PMR_IDLE ##1 s_q.mode == PMR_IDLE |-> o_periph_clk_en || $past(o_periph_clk_en);
   endproperty
   a_periph_runs: assert property (p_periph_runs) else $error("peripheral clock stopped");

   property p_idle_exit;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         s_q.mode == PMR_IDLE && i_irq_taken && !chip_rst
            |=> s_q.mode == PMR_RUN && !s_q.power_control[0] && o_wake_irq;
   endproperty
   a_idle_exit: assert property (p_idle_exit) else $error("idle exit wrong");

   property p_pd_entry;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         s_q.mode == PMR_RUN && wr_power && i_wdata[1] && !chip_rst
            |=> s_q.mode == PMR_PDOWN && !o_osc_en;
   endproperty
   a_pd_entry: assert property (p_pd_entry) else $error("power-down not entered");

   property p_pd_frozen;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         s_q.mode == PMR_PDOWN ##1 s_q.mode == PMR_PDOWN
            |-> $stable(s_q.mc_cnt) && !o_periph_clk_en && !o_osc_en;
   endproperty
   a_pd_frozen: assert property (p_pd_frozen) else $error("clock runs in power-down");

   property p_pd_hold;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         s_q.mode == PMR_PDOWN && !pd_wake && !pin_sync && !chip_rst |=> s_q.mode == PMR_PDOWN;
   endproperty
   a_pd_hold: assert property (p_pd_hold) else $error("power-down left without cause");

   property p_low_gain;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         o_osc_low_gain != i_sec_bit7;
   endproperty
   a_low_gain: assert property (p_low_gain) else $error("amplifier gain wrong");

   property p_rst_values;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         chip_rst && !i_wr |=> o_ports == 32'hffffffff && o_stack == 8'h07
            && (o_power_control & 8'hef) == 8'h00
            && o_power_control[4] == $past(o_power_control[4]);
   endproperty
   a_rst_values: assert property (p_rst_values) else $error("reset values wrong");

   property p_serial_buffer_kept;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         chip_rst && !(i_wr && i_addr == 8'h99) |=> $stable(o_serial_buffer);
   endproperty
   a_serial_buffer_kept: assert property (p_serial_buffer_kept) else $error("serial buffer disturbed");

   property p_half_rate;
      @(posedge i_core_clk) disable iff (!i_arst_n)
         o_periph_clk_en |=> !o_periph_clk_en;
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("clock not divided by two");

endmodule

// File: verif/pmr_ext_model.sv
// external reset circuit and external interrupt sources model
`timescale 1ns/1ps

module pmr_ext_model (
   // clock
   input  wire logic i_core_clk,
   // pins towards the block
   output logic      o_rst_pin,
   output logic      o_irq_zero_n,
   output logic      o_irq_one_n
);
   // ---------------------------------------------------------------------
   // idle levels
   // ---------------------------------------------------------------------
   // reset pin has a pull-low, interrupt pins float high when released
   initial begin
      o_rst_pin    = 1'b0;
      o_irq_zero_n = 1'b1;
      o_irq_one_n  = 1'b1;
   end

   // ---------------------------------------------------------------------
   // commands
   // ---------------------------------------------------------------------
   // a real supply holds at least two machine cycles; short n is a glitch
   task automatic drive_rst(input int n);
      @(posedge i_core_clk);
      o_rst_pin <= 1'b1;
      repeat (n) @(posedge i_core_clk);
      o_rst_pin <= 1'b0;
   endtask

   task automatic set_irq(input int idx, input logic lvl_n);
      @(posedge i_core_clk);
      if (idx == 0) begin
         o_irq_zero_n <= lvl_n;
      end else begin
         o_irq_one_n <= lvl_n;
      end
   endtask
endmodule

// File: verif/tb_top.sv
// self-checking testbench of the power mode and reset control block
`timescale 1ns/1ps
`include "pmr_params.svh"

module tb_top;
   import pmr_pkg::*;
   logic        i_core_clk;
   logic        i_arst_n;
   logic [7:0]  i_addr;
   logic [7:0]  i_wdata;
   logic        i_wr;
   logic        i_rd;
   logic        i_irq_taken;
   logic [1:0]  i_ext_irq_en;
   logic [1:0]  i_ext_irq_level;
   logic        i_sec_bit7;
   wire         rst_pin;
   wire         irq0_n;
   wire         irq1_n;
   logic        o_core_clk_en;
   logic        o_periph_clk_en;
   logic        o_osc_en;
   logic        o_osc_low_gain;
   logic        o_chip_rst;
   logic        o_wake_irq;
   logic [7:0]  o_rdata;
   logic [7:0]  o_power_control;
   logic [7:0]  o_stack;
   logic [31:0] o_ports;
   logic [7:0]  o_serial_buffer;
   logic [2:0]  o_mode;
   int          error_cnt;
   int          n_tests;
   int          nc;
   int          np;
   logic        seen;

   pmr_top u_pmr_top (
      .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rst_pin(rst_pin),
      .i_ext_irq_zero_n(irq0_n), .i_ext_irq_one_n(irq1_n), .i_irq_taken(i_irq_taken),
      .i_ext_irq_en(i_ext_irq_en), .i_ext_irq_level(i_ext_irq_level),
      .i_sec_bit7(i_sec_bit7), .o_core_clk_en(o_core_clk_en),
      .o_periph_clk_en(o_periph_clk_en), .o_osc_en(o_osc_en),
      .o_osc_low_gain(o_osc_low_gain), .o_chip_rst(o_chip_rst), .o_wake_irq(o_wake_irq),
      .o_power_control(o_power_control), .o_stack(o_stack), .o_ports(o_ports),
      .o_serial_buffer(o_serial_buffer), .o_mode(o_mode));

   pmr_ext_model u_pmr_ext_model (
      .i_core_clk(i_core_clk), .o_rst_pin(rst_pin), .o_irq_zero_n(irq0_n),
      .o_irq_one_n(irq1_n));

   // ---------------------------------------------------------------------
   // clock and helpers
   // ---------------------------------------------------------------------
   always #12.5 i_core_clk = ~i_core_clk;

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_core_clk);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr    <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge i_core_clk);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd   <= 1'b0;
      #1;
      chk(name, {24'h0, exp}, {24'h0, o_rdata});
   endtask

   // counts enable pulses over one machine cycle
   task automatic count_en();
      nc = 0;
      np = 0;
      repeat (`PMR_OSC_PER_MC) begin
         @(posedge i_core_clk);
         #1;
         nc += int'(o_core_clk_en === 1'b1);
         np += int'(o_periph_clk_en === 1'b1);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d of %0d checks", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #125000;
      error_cnt++;
      finish_test();
   end

   // ---------------------------------------------------------------------
   // tests
   // ---------------------------------------------------------------------
   initial begin
      i_core_clk = 1'b0;
      i_arst_n = 1'b0;
      {i_addr, i_wdata, i_wr, i_rd, i_irq_taken} = '0;
      i_ext_irq_en = 2'b00;
      i_ext_irq_level = 2'b00;
      i_sec_bit7 = 1'b1;
      error_cnt = 0;
      n_tests = 0;
      repeat (2) @(posedge i_core_clk);
      i_arst_n <= 1'b1;
      // power-on values through the register port
      rd(`PMR_ADDR_POWER, 8'h30, "power_control");
      rd(`PMR_ADDR_STACK, 8'h07, "stack");
      rd(`PMR_ADDR_PORT0, 8'hff, "port0");
      rd(`PMR_ADDR_PORT1, 8'hff, "port1");
      rd(`PMR_ADDR_PORT2, 8'hff, "port2");
      rd(`PMR_ADDR_PORT3, 8'hff, "port3");
      @(posedge i_core_clk);
      #1;
      chk("rdata one cycle", 0, o_rdata);
      rd(8'h85, 8'h00, "unmapped");
      count_en();
      chk("run core enables", 6, nc);
      chk("run periph enables", 6, np);
      @(posedge i_core_clk);
      i_sec_bit7 <= 1'b0;
      @(posedge i_core_clk);
      #1;
      chk("low gain", 1, o_osc_low_gain);
      i_sec_bit7 <= 1'b1;
      @(posedge i_core_clk);
      #1;
      chk("full gain", 0, o_osc_low_gain);
      // idle entry, clocking and interrupt exit
      wr(`PMR_ADDR_POWER, 8'h01);
      chk("idle mode", PMR_IDLE, o_mode);
      count_en();
      chk("idle core enables", 0, nc);
      chk("idle periph enables", 6, np);
      chk("idle osc", 1, o_osc_en);
      @(posedge i_core_clk);
      i_irq_taken <= 1'b1;
      @(posedge i_core_clk);
      i_irq_taken <= 1'b0;
      #1;
      chk("idle exit mode", PMR_RUN, o_mode);
      chk("idle exit wake", 1, o_wake_irq);
      chk("idle bit cleared", 0, o_power_control[`PMR_BIT_IDLE]);
      @(posedge i_core_clk);
      #1;
      chk("wake one cycle", 0, o_wake_irq);
      // power-down: edge-type source and a stray accept must not wake
      wr(`PMR_ADDR_POWER, 8'h02);
      chk("pdown mode", PMR_PDOWN, o_mode);
      chk("pdown osc", 0, o_osc_en);
      chk("pdown periph", 0, o_periph_clk_en);
      chk("pdown core", 0, o_core_clk_en);
      @(posedge i_core_clk);
      i_ext_irq_en <= 2'b11;
      u_pmr_ext_model.set_irq(1, 1'b0);
      i_irq_taken <= 1'b1;
      @(posedge i_core_clk);
      i_irq_taken <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      #1;
      chk("pdown edge irq ignored", PMR_PDOWN, o_mode);
      @(posedge i_core_clk);
      i_ext_irq_level <= 2'b10;
      seen = 1'b0;
      for (int k = 0; k < 8 && !seen; k++) begin
         @(posedge i_core_clk);
         #1;
         seen = (o_mode === PMR_RUN);
      end
      chk("pdown level wake", 1, seen);
      chk("pdown wake pulse", 1, o_wake_irq);
      chk("pdown bit cleared", 0, o_power_control[`PMR_BIT_PDOWN]);
      u_pmr_ext_model.set_irq(1, 1'b1);
      i_ext_irq_en <= 2'b00;
      i_ext_irq_level <= 2'b00;
      // reset glitch of one sample only
      u_pmr_ext_model.drive_rst(8);
      seen = 1'b0;
      repeat (40) begin
         @(posedge i_core_clk);
         #1;
         seen |= (o_chip_rst === 1'b1);
      end
      chk("glitch ignored", 0, seen);
      // held reset loads the reset values, keeps bit four and serial_buffer
      wr(`PMR_ADDR_STACK, 8'h55);
      wr(`PMR_ADDR_PORT1, 8'h12);
      wr(`PMR_ADDR_SERIAL, 8'ha5);
      wr(`PMR_ADDR_POWER, 8'h92);
      chk("pre pdown", PMR_PDOWN, o_mode);
      chk("pre stack", 8'h55, o_stack);
      u_pmr_ext_model.drive_rst(4 * `PMR_OSC_PER_MC);
      #1;
      chk("chip reset", 1, o_chip_rst);
      chk("rst stack", `PMR_STACK_RST, o_stack);
      chk("rst ports", 32'hffffffff, o_ports);
      chk("rst power", 8'h10, o_power_control);
      chk("rst serial", 8'ha5, o_serial_buffer);
      chk("rst mode", PMR_RUN, o_mode);
      seen = 1'b1;
      for (int k = 0; k < 20 && seen; k++) begin
         @(posedge i_core_clk);
         #1;
         seen = (o_chip_rst === 1'b1);
      end
      chk("chip reset released", 0, seen);
      rd(`PMR_ADDR_SERIAL, 8'ha5, "serial kept");
      rd(`PMR_ADDR_POWER, 8'h10, "power bit four");
      finish_test();
   end
endmodule
